/* File: design/tcm_defs.svh */
// constants and behaviour notes for the translation cache maintenance block
// Notes on behaviour
// - indirect segment access selects register by top four bits of index source; here avs_address bits 5:2 select it.
// - entry invalidate clears hit entries and broadcasts a bus invalidate; here it clears every instruction buffer entry.
// - sixteen 32-bit segment registers; bit 0 selects field meaning.
// - eight block translation registers in four upper/lower pairs.
// - one 32-bit table search descriptor register.
// - these registers are reachable only in supervisor mode.
// - snooped invalidate hit stalls new memory ops, then waits for drain.
// - after drain, clear both unified buffer ways at index, then resume.
// - instruction buffer: four entries, fully associative, page or block; here the block flag is ignored, all entries match 20-bit pages.
// - new instruction mappings load automatically into the instruction buffer.
// - instruction buffer used only when instruction translation is enabled.
// - instruction buffer lookup runs independently of data translation.
// - segment, block register writes, invalidates and snoops flush buffer.
// - instruction buffer replacement picks the least recently used entry.
// - every access carries mode bits; coherence bit selects global access.
// - mode bits used only at translation, never stored with cached data.
// - with translation off mode bits are 001.
// - write-through store hit updates cache and writes memory.
// - write-back stores update only cache until copyback.
// - write-through stores may merge unless a sync separates them.
// - cache-inhibited access goes to memory, no load or allocate.
// - cache-inhibited access leaves existing cached copy untouched.
// - cache-inhibited accesses from different instructions never merge.
// - coherent external access asserts the global access signal.
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH
`define TCM_OFF_SEG_BASE 8'h00
`define TCM_OFF_BLK_BASE 8'h40
`define TCM_OFF_TSD 8'h60
`define TCM_OFF_CTRL 8'h64
`define TCM_OFF_STAT 8'h68
`define TCM_CTRL_IXE 0
`define TCM_CTRL_DXE 1
`define TCM_CTRL_SUP 2
`define TCM_STAT_STALL 0
`define TCM_STAT_VBASE 4
`define TCM_CTRL_RESET 3'h7
`define TCM_MODE_DIRECT 3'h1
`define TCM_IDX_MSB 31
`define TCM_IDX_LSB 28
`endif

/* File: design/tcm_pkg.sv */
// types shared by the translation cache maintenance block
package tcm_pkg;
  typedef struct packed {
    logic wt;
    logic ci;
    logic coh;
  } tcm_mode_t;
  typedef struct packed {
    logic [19:0] vpage;
    logic [19:0] ppage;
    logic is_block;
    tcm_mode_t mode;
  } tcm_fill_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic store;
    logic wt;
    logic ci;
    logic global_access_signal;
    logic may_merge;
    logic cache_update;
    logic cache_alloc;
    logic mem_write;
  } tcm_access_t;
  typedef enum logic [2:0] {
    TCM_RUN = 3'b001,
    TCM_DRAIN = 3'b010,
    TCM_CLEAR = 3'b100
  } tcm_snoop_st_t;
endpackage : tcm_pkg

/* File: design/tcm_top.sv */
// translation buffer upkeep, instruction buffer and access mode handling
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_top #(
  parameter int IENT = 4,
  parameter int USETS = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic ifetch_req,
  input wire logic [31:0] ifetch_addr,
  output logic ifetch_hit,
  output logic ifetch_miss,
  output logic [31:0] ifetch_paddr,
  output tcm_pkg::tcm_mode_t ifetch_mode,
  input wire logic fill_valid,
  input wire tcm_pkg::tcm_fill_t fill_data,
  input wire logic inval_entry,
  input wire logic [31:0] inval_addr,
  output logic bus_xlate_invalidate,
  output logic [31:0] bus_inval_addr,
  input wire logic snoop_inval,
  input wire logic [31:0] snoop_addr,
  input wire logic [USETS-1:0] unified_xlate_buffer_valid_at,
  input wire logic mem_outstanding,
  output logic issue_stall,
  output logic unified_xlate_buffer_clear,
  output logic [$clog2(USETS)-1:0] unified_xlate_buffer_clear_index,
  input wire logic dacc_valid,
  input wire logic [31:0] dacc_paddr,
  input wire logic dacc_store,
  input wire logic dacc_sync_before,
  input wire logic dacc_translated,
  input wire tcm_pkg::tcm_mode_t dacc_mode,
  output logic dacc_out_valid,
  output tcm_pkg::tcm_access_t dacc_out
);
  import tcm_pkg::*;
  localparam int UIW = $clog2(USETS);
  localparam int LW = $clog2(IENT);

  logic [31:0] seg_map_r [16];
  logic [31:0] blk_xlate_r [8];
  logic [31:0] tsd_r;
  logic [2:0] ctrl_r;
  logic [IENT-1:0] ivalid_r;
  logic [19:0] ivpage_r [IENT];
  logic [19:0] ippage_r [IENT];
  logic [IENT-1:0] iblock_r;
  tcm_mode_t imode_r [IENT];
  logic [LW-1:0] iage_r [IENT];
  tcm_snoop_st_t snoop_st_r;
  logic [UIW-1:0] snoop_idx_r;
  logic ack_r;
  logic last_store_wt_r;

  wire instr_xlate_enable = ctrl_r[`TCM_CTRL_IXE];
  wire data_xlate_enable = ctrl_r[`TCM_CTRL_DXE];
  wire supervisor = ctrl_r[`TCM_CTRL_SUP];
  wire acc = (avs_read | avs_write) & ~ack_r;
  wire [5:0] widx = avs_address[7:2];
  wire hit_seg = avs_address < `TCM_OFF_BLK_BASE;
  wire hit_blk = (avs_address >= `TCM_OFF_BLK_BASE) && (avs_address < `TCM_OFF_TSD);
  wire hit_tsd = avs_address == `TCM_OFF_TSD;
  wire hit_ctrl = avs_address == `TCM_OFF_CTRL;
  wire hit_stat = avs_address == `TCM_OFF_STAT;
  wire priv_ok = supervisor;
  wire mapped = hit_ctrl | hit_stat | ((hit_seg | hit_blk | hit_tsd) & priv_ok);
  wire wr_go = acc & avs_write & mapped;
  wire seg_wr = wr_go & hit_seg;
  wire blk_wr = wr_go & hit_blk;
  // select of segment by word index bits of the bus address
  wire [3:0] seg_sel = avs_address[5:2]; // bits 5:2 of avs_address land here
  wire [2:0] blk_sel = widx[2:0];

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // bus slave: one wait cycle then answer
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else begin
      ack_r <= acc;
      avs_waitrequest <= ~acc;
      if (acc) begin
        avs_response_err <= ~mapped;
        avs_readdata <= 32'h0000_0000;
        if (avs_read && mapped) begin
          if (hit_seg) begin
            avs_readdata <= seg_map_r[seg_sel];
          end else if (hit_blk) begin
            avs_readdata <= blk_xlate_r[blk_sel];
          end else if (hit_tsd) begin
            avs_readdata <= tsd_r;
          end else if (hit_ctrl) begin
            avs_readdata <= {29'h0, ctrl_r};
          end else begin
            avs_readdata <= {{(28-IENT){1'b0}}, ivalid_r, 3'h0, snoop_st_r != TCM_RUN};
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        seg_map_r[i] <= 32'h0000_0000;
      end
    end else if (seg_wr) begin
      seg_map_r[seg_sel] <= be_merge(seg_map_r[seg_sel], avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        blk_xlate_r[i] <= 32'h0000_0000;
      end
    end else if (blk_wr) begin
      blk_xlate_r[blk_sel] <= be_merge(blk_xlate_r[blk_sel], avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tsd_r <= 32'h0000_0000;
      ctrl_r <= `TCM_CTRL_RESET;
    end else begin
      if (wr_go && hit_tsd) begin
        tsd_r <= be_merge(tsd_r, avs_writedata, avs_byteenable);
      end
      if (wr_go && hit_ctrl && avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[2:0];
      end
    end
  end

  // snooped invalidate sequence
  wire [UIW-1:0] snoop_index = snoop_addr[12 +: UIW];
  wire snoop_hit = snoop_inval & unified_xlate_buffer_valid_at[snoop_index];
  always_ff @(posedge clk) begin
    if (srst) begin
      snoop_st_r <= TCM_RUN;
      snoop_idx_r <= '0;
      unified_xlate_buffer_clear <= 1'b0;
      unified_xlate_buffer_clear_index <= '0;
      issue_stall <= 1'b0;
    end else begin
      unified_xlate_buffer_clear <= 1'b0;
      case (snoop_st_r)
        TCM_RUN: begin
          if (snoop_hit) begin
            snoop_st_r <= TCM_DRAIN;
            snoop_idx_r <= snoop_index;
            issue_stall <= 1'b1;
          end
        end
        TCM_DRAIN: begin
          if (!mem_outstanding) begin
            snoop_st_r <= TCM_CLEAR;
            unified_xlate_buffer_clear <= 1'b1; // both ways at index
            unified_xlate_buffer_clear_index <= snoop_idx_r;
          end
        end
        TCM_CLEAR: begin
          snoop_st_r <= TCM_RUN;
          issue_stall <= 1'b0;
        end
        default: begin
          snoop_st_r <= TCM_RUN;
          issue_stall <= 1'b0;
        end
      endcase
    end
  end

  // entry invalidate broadcast
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_xlate_invalidate <= 1'b0;
      bus_inval_addr <= 32'h0000_0000;
    end else begin
      bus_xlate_invalidate <= inval_entry;
      if (inval_entry) begin
        bus_inval_addr <= inval_addr;
      end
    end
  end

  // instruction translation buffer
  logic [IENT-1:0] ihit_vec;
  logic [LW-1:0] ihit_idx;
  logic [LW-1:0] victim;
  always_comb begin
    ihit_vec = '0;
    ihit_idx = '0;
    victim = '0;
    for (int i = 0; i < IENT; i++) begin
      if (ivalid_r[i] && ivpage_r[i] == ifetch_addr[31:12]) begin
        ihit_vec[i] = 1'b1;
        ihit_idx = LW'(i);
      end
      if (iage_r[i] == LW'(IENT-1)) begin
        victim = LW'(i);
      end
    end
  end

  wire flush_all = seg_wr | blk_wr | inval_entry | snoop_inval;
  wire ilookup = ifetch_req & instr_xlate_enable;
  logic [LW-1:0] fill_slot;
  always_comb begin
    fill_slot = victim;
    for (int i = 0; i < IENT; i++) begin
      if (!ivalid_r[i]) begin
        fill_slot = LW'(i);
      end
    end
  end
  wire do_fill = fill_valid & ~flush_all;
  wire touch = do_fill | (ilookup & |ihit_vec);
  wire [LW-1:0] touch_idx = do_fill ? fill_slot : ihit_idx;

  always_ff @(posedge clk) begin
    if (srst) begin
      ivalid_r <= '0;
    end else if (flush_all) begin
      ivalid_r <= '0;
    end else if (do_fill) begin
      ivalid_r[fill_slot] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_fill) begin
      ivpage_r[fill_slot] <= fill_data.vpage;
      ippage_r[fill_slot] <= fill_data.ppage;
      iblock_r[fill_slot] <= fill_data.is_block;
      imode_r[fill_slot] <= fill_data.mode;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < IENT; i++) begin
        iage_r[i] <= LW'(i);
      end
    end else if (touch) begin
      for (int i = 0; i < IENT; i++) begin
        if (LW'(i) == touch_idx) begin
          iage_r[i] <= '0;
        end else if (iage_r[i] < iage_r[touch_idx]) begin
          iage_r[i] <= iage_r[i] + LW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ifetch_hit <= 1'b0;
      ifetch_miss <= 1'b0;
      ifetch_paddr <= 32'h0000_0000;
      ifetch_mode <= `TCM_MODE_DIRECT;
    end else begin
      ifetch_hit <= 1'b0;
      ifetch_miss <= 1'b0;
      if (ifetch_req && !instr_xlate_enable) begin
        ifetch_hit <= 1'b1;
        ifetch_paddr <= ifetch_addr;
        ifetch_mode <= `TCM_MODE_DIRECT;
      end else if (ilookup && |ihit_vec && !flush_all) begin
        ifetch_hit <= 1'b1;
        ifetch_paddr <= {ippage_r[ihit_idx], ifetch_addr[11:0]};
        ifetch_mode <= imode_r[ihit_idx];
      end else if (ilookup) begin
        ifetch_miss <= 1'b1;
      end
    end
  end

  // data access mode handling; mode bits not kept past this stage
  tcm_mode_t eff_mode;
  always_comb begin
    eff_mode = (dacc_translated && data_xlate_enable) ? dacc_mode : `TCM_MODE_DIRECT;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dacc_out_valid <= 1'b0;
      dacc_out <= '0;
      last_store_wt_r <= 1'b0;
    end else begin
      dacc_out_valid <= dacc_valid & ~issue_stall;
      if (dacc_valid && !issue_stall) begin
        dacc_out.paddr <= dacc_paddr;
        dacc_out.store <= dacc_store;
        dacc_out.wt <= eff_mode.wt; // passed out, not stored
        dacc_out.ci <= eff_mode.ci;
        dacc_out.global_access_signal <= eff_mode.coh & (eff_mode.ci | eff_mode.wt | 1'b1);
        dacc_out.cache_update <= ~eff_mode.ci;
        dacc_out.cache_alloc <= ~eff_mode.ci;
        dacc_out.mem_write <= dacc_store & (eff_mode.wt | eff_mode.ci);
        dacc_out.may_merge <= dacc_store & eff_mode.wt & ~eff_mode.ci & last_store_wt_r
                              & ~dacc_sync_before;
        last_store_wt_r <= dacc_store & eff_mode.wt & ~eff_mode.ci;
      end
    end
  end

  wire unused_ok = ^{iblock_r, avs_address[1:0], widx[5:3]};
endmodule : tcm_top

/* File: verification/tcm_checker.sv */
// assertions on the translation cache maintenance top level
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_checker #(
  parameter int USETS = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic inval_entry,
  input wire logic [31:0] inval_addr,
  input wire logic bus_xlate_invalidate,
  input wire logic [31:0] bus_inval_addr,
  input wire logic snoop_inval,
  input wire logic [31:0] snoop_addr,
  input wire logic [USETS-1:0] unified_xlate_buffer_valid_at,
  input wire logic mem_outstanding,
  input wire logic issue_stall,
  input wire logic unified_xlate_buffer_clear,
  input wire logic dacc_valid,
  input wire logic dacc_translated,
  input wire tcm_pkg::tcm_mode_t dacc_mode,
  input wire logic dacc_out_valid,
  input wire tcm_pkg::tcm_access_t dacc_out
);
  import tcm_pkg::*;
  localparam int IW = $clog2(USETS);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  localparam logic [2:0] CRST = `TCM_CTRL_RESET;
  // shadow of the data translation enable, taken at the bus answer
  logic dxe_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      dxe_r <= CRST[`TCM_CTRL_DXE];
    end else if (avs_write && !avs_waitrequest && avs_address == `TCM_OFF_CTRL) begin
      dxe_r <= avs_writedata[`TCM_CTRL_DXE];
    end
  end
  sequence s_drained;
    issue_stall && !unified_xlate_buffer_clear && !mem_outstanding;
  endsequence
  sequence s_clear;
    unified_xlate_buffer_clear ##1 !issue_stall;
  endsequence
  property p_bcast;
    inval_entry |=> bus_xlate_invalidate && bus_inval_addr == $past(inval_addr);
  endproperty
  a_bcast: assert property (p_bcast) else $error("no broadcast");
  property p_stall;
    snoop_inval && unified_xlate_buffer_valid_at[snoop_addr[12+:IW]] |=> issue_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_wait;
    issue_stall && mem_outstanding && !unified_xlate_buffer_clear |=> issue_stall && !unified_xlate_buffer_clear;
  endproperty
  a_wait: assert property (p_wait) else $error("no drain wait");
  property p_clear;
    s_drained |=> s_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_hold;
    dacc_valid && issue_stall |=> !dacc_out_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("issued in stall");
  property p_pass;
    dacc_valid && !issue_stall && dacc_translated && dxe_r |=> dacc_out_valid &&
      {dacc_out.wt, dacc_out.ci, dacc_out.global_access_signal} == $past(dacc_mode);
  endproperty
  a_pass: assert property (p_pass) else $error("bad mode");
  property p_direct;
    dacc_valid && !issue_stall && !(dacc_translated && dxe_r) |=>
      {dacc_out.wt, dacc_out.ci, dacc_out.global_access_signal} == 3'h1;
  endproperty
  a_direct: assert property (p_direct) else $error("bad direct mode");
  property p_inhibit;
    dacc_out_valid && dacc_out.ci |->
      !dacc_out.cache_alloc && !dacc_out.cache_update && !dacc_out.may_merge;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("bad inhibit");
  property p_store;
    dacc_out_valid && dacc_out.store |-> dacc_out.mem_write == (dacc_out.wt || dacc_out.ci);
  endproperty
  a_store: assert property (p_store) else $error("bad store");
endmodule : tcm_checker

bind tcm_top tcm_checker #(.USETS(USETS)) u_chk (.clk(clk), .srst(srst),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest),
  .inval_entry(inval_entry), .inval_addr(inval_addr),
  .bus_xlate_invalidate(bus_xlate_invalidate), .bus_inval_addr(bus_inval_addr),
  .snoop_inval(snoop_inval), .snoop_addr(snoop_addr), .unified_xlate_buffer_valid_at(unified_xlate_buffer_valid_at),
  .mem_outstanding(mem_outstanding), .issue_stall(issue_stall), .unified_xlate_buffer_clear(unified_xlate_buffer_clear),
  .dacc_valid(dacc_valid), .dacc_translated(dacc_translated), .dacc_mode(dacc_mode),
  .dacc_out_valid(dacc_out_valid), .dacc_out(dacc_out));

/* File: verification/tcm_peer.sv */
// far side model: snooping bus peer and outstanding memory traffic
`timescale 1ns/1ps
module tcm_peer (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] lag,
  output logic snoop_inval,
  output logic [31:0] snoop_addr,
  output logic mem_outstanding
);
  logic [3:0] cnt_r;
  initial begin
    snoop_inval = 1'b0;
    snoop_addr = 32'h0;
  end
  task automatic snoop(input logic [31:0] a);
    @(posedge clk);
    snoop_inval <= 1'b1;
    snoop_addr <= a;
    @(posedge clk);
    snoop_inval <= 1'b0;
    snoop_addr <= ~a;
  endtask : snoop
  // memory traffic still in flight when a snoop lands
  always_ff @(posedge clk) begin
    if (srst) cnt_r <= 4'h0;
    else if (snoop_inval) cnt_r <= lag;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign mem_outstanding = cnt_r != 4'h0;
endmodule : tcm_peer

/* File: verification/tb_translation_cache_maintenance.sv */
// self-checking bench for the translation cache maintenance block
`timescale 1ns/1ps
module tb_translation_cache_maintenance;
  import tcm_pkg::*;
  logic clk, srst, avs_read, avs_write, ifetch_req, fill_valid, inval_entry, dacc_valid;
  logic dacc_store, dacc_sync_before, dacc_translated, snoop_inval, mem_outstanding;
  logic avs_waitrequest, avs_response_err, ifetch_hit, ifetch_miss, bus_xlate_invalidate;
  logic issue_stall, unified_xlate_buffer_clear, dacc_out_valid;
  logic pw, dxe_on;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, ifetch_addr, inval_addr, snoop_addr, unified_xlate_buffer_valid_at, dacc_paddr;
  logic [31:0] avs_readdata, ifetch_paddr, bus_inval_addr, r;
  logic [3:0] lag;
  logic [4:0] unified_xlate_buffer_clear_index;
  tcm_fill_t fill_data;
  tcm_mode_t dacc_mode, ifetch_mode;
  tcm_access_t dacc_out;
  tcm_mode_t access_mode_bits[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3};
  logic [63:0] q[$];
  logic [31:0] mir[25];
  logic [19:0] pp[5];
  int err_count, n_checks, i, k;
  tcm_top u_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .ifetch_req(ifetch_req), .ifetch_addr(ifetch_addr),
    .ifetch_hit(ifetch_hit), .ifetch_miss(ifetch_miss), .ifetch_paddr(ifetch_paddr),
    .ifetch_mode(ifetch_mode), .fill_valid(fill_valid), .fill_data(fill_data),
    .inval_entry(inval_entry), .inval_addr(inval_addr),
    .bus_xlate_invalidate(bus_xlate_invalidate), .bus_inval_addr(bus_inval_addr),
    .snoop_inval(snoop_inval), .snoop_addr(snoop_addr), .unified_xlate_buffer_valid_at(unified_xlate_buffer_valid_at),
    .mem_outstanding(mem_outstanding), .issue_stall(issue_stall), .unified_xlate_buffer_clear(unified_xlate_buffer_clear),
    .unified_xlate_buffer_clear_index(unified_xlate_buffer_clear_index), .dacc_valid(dacc_valid), .dacc_paddr(dacc_paddr),
    .dacc_store(dacc_store), .dacc_sync_before(dacc_sync_before),
    .dacc_translated(dacc_translated), .dacc_mode(dacc_mode),
    .dacc_out_valid(dacc_out_valid), .dacc_out(dacc_out));
  tcm_peer u_peer (.clk(clk), .srst(srst), .lag(lag), .snoop_inval(snoop_inval),
    .snoop_addr(snoop_addr), .mem_outstanding(mem_outstanding));
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    if (!w) q.push_back(64'(e));
    @(posedge clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic fet(input logic [31:0] a, input logic [35:0] e);
    @(posedge clk);
    ifetch_req <= 1'b1;
    ifetch_addr <= a;
    q.push_back(64'(e));
    @(posedge clk);
    ifetch_req <= 1'b0;
  endtask : fet
  task automatic fil(input logic [19:0] v, input logic [19:0] p, input tcm_mode_t m);
    @(posedge clk);
    fill_valid <= 1'b1;
    fill_data <= {v, p, 1'b0, m};
    @(posedge clk);
    fill_valid <= 1'b0;
  endtask : fil
  task automatic dac(input logic tr, input tcm_mode_t m, input logic [31:0] p,
                     input logic st, input logic pu);
    tcm_mode_t x;
    logic sy;
    logic mw;
    x = (tr && dxe_on) ? m : 3'h1;
    sy = 1'($urandom);
    mw = st && x.wt && !x.ci;
    @(posedge clk);
    dacc_valid <= 1'b1;
    dacc_translated <= tr;
    dacc_mode <= m;
    dacc_paddr <= p;
    dacc_store <= st;
    dacc_sync_before <= sy;
    if (pu) begin
      q.push_back(64'({p, x, st, st && (x.wt || x.ci), mw && pw && !sy, !x.ci, !x.ci}));
      pw = mw;
    end
    @(posedge clk);
    dacc_valid <= 1'b0;
  endtask : dac
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest)
      chk(64'({avs_response_err, avs_readdata}), q.pop_front());
    if (ifetch_hit || ifetch_miss)
      chk(ifetch_hit ? 64'({1'b1, ifetch_paddr, ifetch_mode}) : 64'h0, q.pop_front());
    if (dacc_out_valid)
      chk(64'({dacc_out.paddr, dacc_out.wt, dacc_out.ci, dacc_out.global_access_signal,
               dacc_out.store, dacc_out.mem_write, dacc_out.may_merge, dacc_out.cache_update,
               dacc_out.cache_alloc}), q.pop_front());
    if (unified_xlate_buffer_clear) chk(64'(unified_xlate_buffer_clear_index), q.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    {srst, avs_read, avs_write, ifetch_req, fill_valid, inval_entry, dacc_valid} = 7'h7F;
    {avs_read, avs_write, ifetch_req, fill_valid, inval_entry, dacc_valid} = 6'h0;
    {dacc_store, dacc_sync_before, dacc_translated, dacc_mode, lag} = 10'h0;
    {avs_address, avs_writedata, ifetch_addr, inval_addr, dacc_paddr} = 136'h0;
    unified_xlate_buffer_valid_at = 32'h0;
    fill_data = '0;
    {pw, dxe_on} = 2'b01;
    void'($urandom(32'h7861));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    acc(1'b0, 8'h64, 0, 33'h7);
    acc(1'b0, 8'h68, 0, 33'h0);
    for (i = 0; i < 25; i++) begin
      mir[i] = $urandom;
      acc(1'b1, 8'(i * 4), mir[i], 0);
    end
    for (i = 0; i < 25; i++) acc(1'b0, 8'(i * 4), 0, {1'b0, mir[i]});
    acc(1'b1, 8'h64, 32'h3, 0);
    acc(1'b0, 8'h00, 0, 33'h1_0000_0000);
    acc(1'b1, 8'h40, ~mir[16], 0);
    acc(1'b1, 8'h64, 32'h6, 0);
    acc(1'b0, 8'h40, 0, {1'b0, mir[16]});
    acc(1'b0, 8'h80, 0, 33'h1_0000_0000);
    r = $urandom;
    fet(r, {1'b1, r, 3'h1});
    acc(1'b1, 8'h64, 32'h7, 0);
    for (i = 0; i < 5; i++) pp[i] = 20'($urandom);
    for (i = 0; i < 4; i++) fil(20'(i + 16), pp[i], 3'(i));
    fet({20'd16, 12'h123}, {1'b1, pp[0], 12'h123, 3'h0});
    fil(20'd20, pp[4], 3'h5);
    fet({20'd17, 12'h0}, 36'h0);
    for (i = 0; i < 5; i++)
      if (i != 1) fet({20'(i + 16), 12'hABC}, {1'b1, pp[i], 12'hABC, 3'(i == 4 ? 5 : i)});
    for (k = 0; k < 4; k++) begin
      fil(20'd9, pp[0], 3'h1);
      fet({20'd9, 12'h0}, {1'b1, pp[0], 12'h0, 3'h1});
      case (k)
        0: acc(1'b1, 8'h08, $urandom, 0);
        1: acc(1'b1, 8'h48, $urandom, 0);
        2: begin
          @(posedge clk);
          inval_entry <= 1'b1;
          inval_addr <= {20'd9, 12'h0};
          @(posedge clk);
          inval_entry <= 1'b0;
        end
        default: u_peer.snoop(32'h0);
      endcase
      fet({20'd9, 12'h0}, 36'h0);
    end
    for (k = 0; k < 2; k++) begin
      r = $urandom;
      lag <= 4'(k * 3);
      unified_xlate_buffer_valid_at <= $urandom | (32'h1 << r[16:12]);
      q.push_back(64'(r[16:12]));
      u_peer.snoop(r);
      if (k == 1) dac(1'b1, 3'h1, r, 1'b0, 1'b0);
      repeat (8) @(posedge clk);
    end
    for (i = 0; i < 18; i++)
      dac(i < 12 || i > 13, i < 12 ? access_mode_bits[i / 2] : (i < 14 ? 3'($urandom) : 3'h4), $urandom,
          i[0] || i > 13, 1'b1);
    acc(1'b1, 8'h64, 32'h5, 0);
    dxe_on = 1'b0;
    dac(1'b1, 3'h2, $urandom, 1'b1, 1'b1);
    fil(20'd5, pp[1], 3'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    fet({20'd5, 12'h0}, 36'h0);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : tb_translation_cache_maintenance
